// [verilog/tcwg_defines.vh]
// constants for the 16-bit timer/counter with compare waveform outputs
// ----------------------------------------------------------------------
// Notes on behaviour
// R1: bottom point is reached when the counter is 0x0000.
// R2: maximum point is the counter value with all bits one.
// R3: top point is the highest value of the active count sequence.
// R4: at update, valid buffers copy into targets unless lock update is set.
// R5: software sets period then enable; counting follows the prescaler.
// R6: count-on-event makes event pulses advance the counter.
// R7: count up or down per direction bit until top or bottom.
// R8: counting up at top, the counter goes to zero on next tick.
// R9: counting down at bottom, the counter reloads the period value.
// R10: counter write acts at once, overriding count, clear or reload.
// R11: direction may change while running; counting follows it.
// R12: period and compares have buffers; write sets valid, update clears.
// R13: compare and compare buffer are each directly writable and readable.
// R14: unbuffered period write takes effect immediately.
// R15: new top below count while counting up runs on to wrap first.
// R16: period buffer writable anytime; period changes only at update.
// R17: counter equal compare signals match; flag sets next cycle.
// R18: compare buffers transfer only at the update point.
// R19: waveform drives pin only in waveform mode, clock ticks, channel on.
// R20: frequency mode takes its period from compare channel zero.
// R21: frequency mode toggles the output on every channel match.
// R22: compare zero at zero, no prescale gives half clock rate output.
// R23: all value registers are 16 bits; prescaler divides per clock select.
// ----------------------------------------------------------------------
`ifndef TCWG_DEFINES_VH
`define TCWG_DEFINES_VH

`define TCWG_W          16
`define TCWG_NCH        3
`define TCWG_ZERO       16'h0000
`define TCWG_ONES       16'hFFFF
`define TCWG_ONE        16'h0001
`define TCWG_PS_W       10
`define TCWG_PS_ZERO    10'h000
`define TCWG_PS_ONE     10'h001

// prescaler masks, one less than the divider
`define TCWG_PS_DIV1    10'h000
`define TCWG_PS_DIV2    10'h001
`define TCWG_PS_DIV4    10'h003
`define TCWG_PS_DIV8    10'h007
`define TCWG_PS_DIV16   10'h00F
`define TCWG_PS_DIV64   10'h03F
`define TCWG_PS_DIV256  10'h0FF
`define TCWG_PS_DIV1024 10'h3FF

// waveform mode select codes
`define TCWG_WG_NORMAL  3'h0
`define TCWG_WG_FRQ     3'h1
`define TCWG_WG_SINGLE  3'h3
`define TCWG_WG_DUAL_T  3'h5
`define TCWG_WG_DUAL_B  3'h7

`endif

// [verilog/tcwg_timer.v]
// 16-bit timer/counter with period, buffered compares and waveform outputs
`timescale 1ns/1ps
`include "tcwg_defines.vh"

module tcwg_timer (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // configuration
  input  wire        enable,
  input  wire [2:0]  clock_select,
  input  wire        count_on_event_enable,
  input  wire        direction,
  input  wire        lock_update,
  input  wire [2:0]  waveform_mode_select,
  input  wire [2:0]  compare_channel_enable,
  // event input, one-cycle pulse from same-clock logic
  input  wire        event_in,
  // counter write
  input  wire        counter_write,
  input  wire [15:0] counter_wdata,
  // period and period buffer writes
  input  wire        period_write,
  input  wire        period_buffer_write,
  input  wire [15:0] period_wdata,
  // compare and compare buffer writes, one strobe per channel
  input  wire [2:0]  compare_write,
  input  wire [2:0]  compare_buffer_write,
  input  wire [15:0] compare_wdata,
  // compare flag clear, one bit per channel
  input  wire [2:0]  compare_flag_clear,
  // state readback
  output reg  [15:0] counter_value,
  output reg  [15:0] period_value,
  output reg  [15:0] period_buffer,
  output reg         period_buffer_valid,
  output wire [47:0] compare_value,
  output wire [47:0] compare_buffer,
  output reg  [2:0]  compare_buffer_valid,
  output reg  [2:0]  compare_flag,
  output wire        at_bottom,
  output wire        at_max,
  output wire        at_top,
  // waveform outputs and pin override
  output reg  [2:0]  waveform_out,
  output wire [2:0]  waveform_override
);

  // ----------------------------------------------------------------------
  // decode and storage
  // ----------------------------------------------------------------------

  // prescaler mask from the clock select field
  function [9:0] tcwg_ps_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    tcwg_ps_mask = `TCWG_PS_DIV1;
        3'h1:    tcwg_ps_mask = `TCWG_PS_DIV2;
        3'h2:    tcwg_ps_mask = `TCWG_PS_DIV4;
        3'h3:    tcwg_ps_mask = `TCWG_PS_DIV8;
        3'h4:    tcwg_ps_mask = `TCWG_PS_DIV16;
        3'h5:    tcwg_ps_mask = `TCWG_PS_DIV64;
        3'h6:    tcwg_ps_mask = `TCWG_PS_DIV256;
        default: tcwg_ps_mask = `TCWG_PS_DIV1024;
      endcase
    end
  endfunction

  reg  [15:0] cmp_reg    [0:2];
  reg  [15:0] cmpbuf_reg [0:2];
  reg  [9:0]  presc_reg;
  wire [9:0]  ps_mask;
  wire        presc_tick;
  wire        count_tick;
  wire [15:0] top_value;
  wire        frq_mode;
  wire        wg_mode;
  wire        hit_top_up;
  wire        hit_bottom_down;
  wire        update_now;
  wire [2:0]  match;

  // ----------------------------------------------------------------------
  // prescaler and tick selection
  // ----------------------------------------------------------------------

  assign ps_mask = tcwg_ps_mask(clock_select);

  // R23 prescale divide
  // the prescaler restarts while disabled so the first period is full
  always @(posedge clk) begin
    if (!reset_n || !enable) begin
      presc_reg <= `TCWG_PS_ZERO;
    end else if ((presc_reg & ps_mask) == ps_mask) begin
      presc_reg <= `TCWG_PS_ZERO;
    end else begin
      presc_reg <= presc_reg + `TCWG_PS_ONE;
    end
  end

  assign presc_tick = ((presc_reg & ps_mask) == ps_mask);

  // R5 enable gates counting
  // R6 events replace prescaled ticks
  assign count_tick = enable &
                      (count_on_event_enable ? event_in : presc_tick);

  // ----------------------------------------------------------------------
  // top, bottom and update points
  // ----------------------------------------------------------------------

  assign frq_mode = (waveform_mode_select == `TCWG_WG_FRQ);
  assign wg_mode  = (waveform_mode_select != `TCWG_WG_NORMAL);

  // R20 frequency period from channel zero
  assign top_value = frq_mode ? cmp_reg[0] : period_value;

  // R1 bottom detect
  assign at_bottom = (counter_value == `TCWG_ZERO);
  // R2 max detect
  assign at_max    = (counter_value == `TCWG_ONES);
  // R3 top detect
  // R15 equality only, so a top below the count waits for the wrap
  assign at_top    = (counter_value == top_value);

  assign hit_top_up      = count_tick && !direction && at_top;
  assign hit_bottom_down = count_tick && direction && at_bottom;

  // R4 update point and lock
  // dual-slope modes update only at the bottom reload, others at both the top wrap and the bottom reload
  assign update_now = !lock_update &&
    (hit_bottom_down ||
     (hit_top_up && waveform_mode_select != `TCWG_WG_DUAL_B &&
      waveform_mode_select != `TCWG_WG_DUAL_T));

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------

  // counter next value; direction is sampled every tick so it may change
  always @(posedge clk) begin
    if (!reset_n) begin
      counter_value <= `TCWG_ZERO;
    end else if (counter_write) begin
      // R10 write overrides counting
      counter_value <= counter_wdata;
    end else if (count_tick) begin
      // R11 live direction change
      // R7 up or down counting
      if (!direction) begin
        // R8 wrap to zero at top
        if (at_top) begin
          counter_value <= `TCWG_ZERO;
        end else begin
          counter_value <= counter_value + `TCWG_ONE;
        end
      end else begin
        // R9 reload at bottom
        if (at_bottom) begin
          counter_value <= top_value;
        end else begin
          counter_value <= counter_value - `TCWG_ONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // period and its buffer
  // ----------------------------------------------------------------------

  // direct write wins over a same-cycle buffer copy
  always @(posedge clk) begin
    if (!reset_n) begin
      period_value        <= `TCWG_ONES;
      period_buffer       <= `TCWG_ZERO;
      period_buffer_valid <= 1'b0;
    end else begin
      if (period_buffer_write) begin
        period_buffer <= period_wdata;
      end
      // R14 unbuffered write immediate
      if (period_write) begin
        period_value <= period_wdata;
      end else if (update_now && period_buffer_valid) begin
        // R16 buffered period at update
        period_value <= period_buffer;
      end
      // R12 valid set and clear
      // a write in the update cycle keeps valid set so nothing is lost
      if (period_buffer_write) begin
        period_buffer_valid <= 1'b1;
      end else if (update_now) begin
        period_buffer_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // compare channels
  // ----------------------------------------------------------------------

  genvar ch;
  generate
    for (ch = 0; ch < `TCWG_NCH; ch = ch + 1) begin : g_ch
      assign compare_value[ch*`TCWG_W +: `TCWG_W]  = cmp_reg[ch];
      assign compare_buffer[ch*`TCWG_W +: `TCWG_W] = cmpbuf_reg[ch];
      // R17 match compare
      assign match[ch] = (counter_value == cmp_reg[ch]);

      // compare register, buffer and valid flag
      always @(posedge clk) begin
        if (!reset_n) begin
          cmp_reg[ch]              <= `TCWG_ZERO;
          cmpbuf_reg[ch]           <= `TCWG_ZERO;
          compare_buffer_valid[ch] <= 1'b0;
        end else begin
          // R13 direct buffer access
          if (compare_buffer_write[ch]) begin
            cmpbuf_reg[ch] <= compare_wdata;
          end
          // R13 direct compare access
          if (compare_write[ch]) begin
            cmp_reg[ch] <= compare_wdata;
          end else if (update_now && compare_buffer_valid[ch]) begin
            // R18 compare copy at update
            cmp_reg[ch] <= cmpbuf_reg[ch];
          end
          // R12 compare valid flag
          if (compare_buffer_write[ch]) begin
            compare_buffer_valid[ch] <= 1'b1;
          end else if (update_now) begin
            compare_buffer_valid[ch] <= 1'b0;
          end
        end
      end

      // R17 flag set next cycle
      // set wins over a clear in the same cycle
      always @(posedge clk) begin
        if (!reset_n) begin
          compare_flag[ch] <= 1'b0;
        end else if (count_tick && match[ch]) begin
          compare_flag[ch] <= 1'b1;
        end else if (compare_flag_clear[ch]) begin
          compare_flag[ch] <= 1'b0;
        end
      end

      // waveform generator per channel
      always @(posedge clk) begin
        if (!reset_n || !wg_mode) begin
          waveform_out[ch] <= 1'b0;
        end else if (frq_mode) begin
          // R21 toggle on match
          // R22 top zero gives a toggle every tick
          if (count_tick && match[ch]) begin
            waveform_out[ch] <= ~waveform_out[ch];
          end
        end else if (count_tick && match[ch]) begin
          // slope modes: clear on match, set at the period start
          waveform_out[ch] <= 1'b0;
        end else if (count_tick && (hit_top_up || hit_bottom_down)) begin
          waveform_out[ch] <= 1'b1;
        end
      end

      // R19 pin override condition
      assign waveform_override[ch] = wg_mode && !count_on_event_enable &&
                                     compare_channel_enable[ch];
    end
  endgenerate

endmodule

// [verification/tcwg_timer_properties.sv]
// port assertions for the 16-bit timer/counter
`timescale 1ns/1ps
module tcwg_timer_props (
  // clock and reset
  input wire        clk,
  input wire        reset_n,
  // controls
  input wire        enable,
  input wire [2:0]  clock_select,
  input wire        count_on_event_enable,
  input wire        direction,
  input wire        lock_update,
  input wire [2:0]  waveform_mode_select,
  input wire [2:0]  compare_channel_enable,
  input wire        counter_write,
  input wire [15:0] counter_wdata,
  input wire        period_write,
  input wire        period_buffer_write,
  input wire [15:0] period_wdata,
  // state
  input wire [15:0] counter_value,
  input wire [15:0] period_value,
  input wire [15:0] period_buffer,
  input wire        period_buffer_valid,
  input wire [47:0] compare_value,
  input wire [2:0]  compare_flag,
  input wire        at_bottom,
  input wire        at_max,
  input wire        at_top,
  input wire [2:0]  waveform_out,
  input wire [2:0]  waveform_override
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // an unprescaled clock tick
  sequence tick_s;
    enable && clock_select == 3'h0 && !count_on_event_enable;
  endsequence
  // tick at top while counting up, no write racing it
  sequence wrap_s;
    tick_s ##0 (!direction && at_top && !counter_write);
  endsequence
  bottom_flag_a: assert property (at_bottom == (counter_value == 16'h0000))
    else $error("bottom flag wrong");
  max_flag_a: assert property (at_max == (counter_value == 16'hFFFF))
    else $error("max flag wrong");
  top_flag_a: assert property (at_top == (counter_value ==
    (waveform_mode_select == 3'h1 ? compare_value[15:0] : period_value)))
    else $error("top flag wrong");
  pin_override_a: assert property (waveform_override ==
    ({3{waveform_mode_select != 3'h0 && !count_on_event_enable}}
    & compare_channel_enable)) else $error("override wrong");
  count_write_a: assert property (counter_write |=>
    counter_value == $past(counter_wdata)) else $error("write lost");
  up_wrap_a: assert property (wrap_s |=> counter_value == 16'h0000)
    else $error("no wrap at top");
  down_reload_a: assert property (tick_s ##0 (direction && at_bottom
    && !counter_write && !period_write && !period_buffer_valid
    && waveform_mode_select == 3'h0) |=> counter_value == $past(period_value))
    else $error("no reload");
  lock_hold_a: assert property (lock_update && !period_write |=>
    $stable(period_value)) else $error("copy under lock");
  buf_valid_a: assert property (period_buffer_write |=>
    period_buffer_valid && period_buffer == $past(period_wdata))
    else $error("buffer write lost");
  match_flag_a: assert property (tick_s ##0
    (counter_value == compare_value[15:0]) |=> compare_flag[0])
    else $error("flag not set");
  freq_toggle_a: assert property (tick_s ##0 (waveform_mode_select == 3'h1
    && counter_value == compare_value[15:0]) |=>
    waveform_out[0] != $past(waveform_out[0])) else $error("no toggle");
endmodule
bind tcwg_timer tcwg_timer_props chk_u (.*);

// [verification/tcwg_timer_tb.sv]
// self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
module tcwg_timer_tb;
  logic        clk, reset_n, enable, count_on_event_enable, direction;
  logic        lock_update, event_in, counter_write, period_write;
  logic        period_buffer_write, b;
  logic [2:0]  clock_select, waveform_mode_select, compare_channel_enable;
  logic [2:0]  compare_write, compare_buffer_write, compare_flag_clear;
  logic [15:0] counter_wdata, period_wdata, compare_wdata;
  wire  [15:0] counter_value, period_value, period_buffer;
  wire  [47:0] compare_value, compare_buffer;
  wire  [2:0]  compare_buffer_valid, compare_flag, waveform_out;
  wire  [2:0]  waveform_override;
  wire         period_buffer_valid, at_bottom, at_max, at_top;
  int          err_total, check_count;
  tcwg_timer dut_u (.*);
  // 100 ns clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task e(input int n);
    repeat (n) @(posedge clk);
  endtask
  task s;
    @(negedge clk);
  endtask
  task chk(input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe: 0 cnt, 1 per, 2 period_buffer, 3 compare_zero_value, 4 cmpbuf1
  task pls(input int k, input logic [15:0] v);
    e(1);
    counter_wdata <= v;
    period_wdata <= v;
    compare_wdata <= v;
    counter_write <= (k == 0);
    period_write <= (k == 1);
    period_buffer_write <= (k == 2);
    compare_write <= {2'h0, k == 3};
    compare_buffer_write <= {1'h0, k == 4, 1'h0};
    e(1);
    {counter_write, period_write, period_buffer_write} <= 3'h0;
    compare_write <= 3'h0;
    compare_buffer_write <= 3'h0;
  endtask
  // follow the counter against a wrap/reload model
  task run(input int n, input logic [15:0] c, p);
    repeat (n) begin
      s;
      chk(counter_value, c);
      c = direction ? (c == 16'h0000 ? p : c - 16'h0001)
                    : (c == p ? 16'h0000 : c + 16'h0001);
    end
  endtask
  task t_count;
    s;
    chk({at_bottom, at_max}, 2'h2);
    pls(1, 16'h0003);
    enable <= 1'h1;
    pls(0, 16'h0000);
    run(6, 16'h0000, 16'h0003);
    e(1);
    direction <= 1'h1;
    pls(0, 16'h0001);
    run(5, 16'h0001, 16'h0003);
    e(1);
    direction <= 1'h0;
  endtask
  task t_buffer;
    pls(2, 16'h0005);
    s;
    chk({period_value, period_buffer_valid}, {16'h0003, 1'h1});
    chk(period_buffer, 16'h0005);
    pls(0, 16'h0000);
    run(4, 16'h0000, 16'h0003);
    s;
    chk({period_value, period_buffer_valid}, {16'h0005, 1'h0});
    e(1);
    lock_update <= 1'h1;
    pls(2, 16'h0002);
    pls(0, 16'h0005);
    e(1);
    s;
    chk({period_value, period_buffer_valid}, {16'h0005, 1'h1});
    e(1);
    lock_update <= 1'h0;
  endtask
  task t_event_scale;
    count_on_event_enable <= 1'h1;
    pls(0, 16'h0000);
    repeat (2) begin
      e(1);
      event_in <= 1'h1;
      e(1);
      event_in <= 1'h0;
    end
    s;
    chk(counter_value, 16'h0002);
    pls(1, 16'h00FF);
    count_on_event_enable <= 1'h0;
    enable <= 1'h0;
    clock_select <= 3'h2;
    pls(0, 16'h0000);
    enable <= 1'h1;
    e(40);
    s;
    chk(counter_value, 16'h000A);
  endtask
  task t_compare;
    e(1);
    clock_select <= 3'h0;
    compare_flag_clear <= 3'h7;
    e(1);
    compare_flag_clear <= 3'h0;
    pls(3, 16'h0004);
    pls(4, 16'h0007);
    s;
    chk({compare_value[31:0], compare_flag[0]}, {32'h4, 1'h0});
    chk({compare_buffer[31:16], compare_buffer_valid}, {16'h7, 3'h2});
    pls(0, 16'h0000);
    run(6, 16'h0000, 16'h00FF);
    chk(compare_flag[0], 1'h1);
    e(1);
    compare_flag_clear <= 3'h1;
    e(1);
    compare_flag_clear <= 3'h0;
    s;
    chk(compare_flag[0], 1'h0);
    pls(0, 16'h00FF);
    e(2);
    s;
    chk(compare_value[31:16], 16'h0007);
    chk({period_value, period_buffer_valid}, {16'h2, 1'h0});
    chk(compare_buffer_valid, 3'h0);
  endtask
  task t_freq;
    e(1);
    waveform_mode_select <= 3'h1;
    compare_channel_enable <= 3'h1;
    pls(3, 16'h0000);
    pls(0, 16'h0000);
    s;
    chk(waveform_override, 3'h1);
    repeat (4) begin
      b = waveform_out[0];
      s;
      chk({counter_value, waveform_out[0]}, {16'h0000, ~b});
    end
    e(1);
    count_on_event_enable <= 1'h1;
    s;
    chk(waveform_override, 3'h0);
    e(1);
    count_on_event_enable <= 1'h0;
    waveform_mode_select <= 3'h0;
    pls(1, 16'h0004);
    pls(0, 16'hFFFD);
    run(5, 16'hFFFD, 16'h0004);
  endtask
  // dual-slope: no copy at the top wrap, copy at the bottom reload
  task t_dual;
    e(1);
    waveform_mode_select <= 3'h5;
    pls(2, 16'h0003);
    e(1);
    s;
    chk({counter_value, period_value}, {16'h0, 16'h4});
    chk(period_buffer_valid, 1'h1);
    e(1);
    direction <= 1'h1;
    e(2);
    s;
    chk({counter_value, period_value}, {16'h4, 16'h3});
    chk(period_buffer_valid, 1'h0);
    e(1);
    direction <= 1'h0;
    waveform_mode_select <= 3'h0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog at 4000 cycles, far beyond the roughly 130 cycles needed
  initial begin
    #400000;
    err_total++;
    close_out;
  end
  // main sequence
  initial begin
    {reset_n, enable, count_on_event_enable, direction, lock_update} = '0;
    {event_in, counter_write, period_write, period_buffer_write} = '0;
    {clock_select, waveform_mode_select, compare_channel_enable} = '0;
    {compare_write, compare_buffer_write, compare_flag_clear} = '0;
    {counter_wdata, period_wdata, compare_wdata} = '0;
    e(2);
    reset_n <= 1'h1;
    t_count;
    t_buffer;
    t_event_scale;
    t_compare;
    t_freq;
    t_dual;
    close_out;
  end
endmodule
